// ---- core/apms_pkg.sv ----
// Shared constants and types for the converter power-mode sequencer.
// Assumes a single 10 MHz system clock; the serial link is sampled, not clocked.
package apms_pkg;

   // ----------------------------------------
   // Frame counts
   // ----------------------------------------
   localparam int unsigned EDGE_CNT_W = 5;
   localparam logic [4:0] EDGE_GLITCH = 5'h02;
   localparam logic [4:0] EDGE_HOLD = 5'h0A;
   localparam logic [4:0] EDGE_FRAME = 5'h10;
   localparam logic [4:0] EDGE_TRACK = 5'h0D;
   localparam logic [4:0] EDGE_ZERO = 5'h00;
   localparam int unsigned RESULT_W = 12;
   localparam int unsigned WORD_W = 16;
   localparam logic [3:0] LEAD_ZEROS = 4'h0;

   // ----------------------------------------
   // Modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      APMS_NORMAL = 2'b00,
      APMS_PARTIAL = 2'b01,
      APMS_FULL = 2'b11
   } apms_mode_e;

   localparam apms_mode_e MODE_RESET = APMS_NORMAL;

   // Synchronised link pins with edge events
   typedef struct packed {
      logic sel_fall;
      logic sel_rise;
      logic clk_fall;
      logic clk_rise;
      logic sel_low;
   } apms_link_s;

endpackage

// ---- core/apms_link_sync.sv ----
// Two-flop synchronisers and edge finders for the select and serial clock pins.
// Assumes pins are asynchronous to clk.
`timescale 1ns/1ns
module apms_link_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sel_n_pin,
   input wire logic sclk_pin,
   output apms_pkg::apms_link_s link
);

   logic [2:0] sel_q;
   logic [2:0] sck_q;

   // ----------------------------------------
   // Synchronise; third stage for edges
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sel_q <= 3'h7;
         sck_q <= 3'h7;
      end else begin
         sel_q <= {sel_q[1:0], sel_n_pin};
         sck_q <= {sck_q[1:0], sclk_pin};
      end
   end

   always_comb begin
      link.sel_fall = sel_q[2] & ~sel_q[1];
      link.sel_rise = ~sel_q[2] & sel_q[1];
      link.clk_fall = sck_q[2] & ~sck_q[1] & ~sel_q[1];
      link.clk_rise = ~sck_q[2] & sck_q[1] & ~sel_q[1];
      link.sel_low = ~sel_q[1];
   end

endmodule

// ---- core/apms_seq.sv ----
// Power-mode sequencer and serial result framing for a 12-bit serial converter.
// Assumes select and serial clock come from an external master, async to clk.
// Summary of operation
// [RQ1] Select falling edge samples input and starts a conversion.
// [RQ2] Select held low past ten falling edges keeps device fully powered.
// [RQ3] Select rising between edges ten and sixteen aborts, stays powered, floats output.
// [RQ4] Sixteen serial clocks in one frame complete conversion and readout.
// [RQ5] Host waits a quiet gap after output floats before next frame.
// [RQ6] Host may idle select high, or low then raise before next frame.
// [RQ7] Normal: select rising between edges two and ten enters partial power-down.
// [RQ8] Normal: select rising before edge two keeps normal mode.
// [RQ9] Dummy frame held past edge ten wakes device from power-down.
// [RQ10] Wake completes after sixteen clocks; only the next frame gives valid data.
// [RQ11] Partial: select rising before edge two returns to partial power-down.
// [RQ12] Partial: select rising between edges two and ten enters full power-down.
// [RQ13] Three modes; next mode set by current mode and select rise point.
// [RQ14] Track-and-hold returns to track on the thirteenth rising clock edge; in a frame begun in power-down the code returns on the first.
// [RQ15] Result shifts out as four zeros then twelve bits, MSB first.
// [RQ16] Host allows a wake delay beyond one dummy frame after full power-down.
// [RQ17] Falling edges counted from each select fall, judged at select rise.
// [RQ18] Serial output floats whenever select is high.
`timescale 1ns/1ns
module apms_seq (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sel_n_pin,
   input wire logic sclk_pin,
   input wire logic [11:0] sample_code,
   output logic serial_result_out,
   output logic serial_result_oe,
   output logic [1:0] power_mode,
   output logic powered,
   output logic tracking,
   output logic result_valid
);

   apms_pkg::apms_link_s link;
   apms_pkg::apms_mode_e mode_q;
   logic [4:0] edges_q;
   logic [4:0] rises_q;
   logic [15:0] shift_q;
   logic active_q;
   logic waking_q;
   logic dummy_q;
   logic oe_q;
   logic track_q;
   logic valid_q;

   apms_link_sync u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .sel_n_pin(sel_n_pin),
      .sclk_pin(sclk_pin),
      .link(link)
   );

   // Window test on the falling-edge count
   function automatic logic in_window(input logic [4:0] n, input logic [4:0] lo, input logic [4:0] hi);
      in_window = (n >= lo) && (n < hi);
   endfunction

   // ----------------------------------------
   // Edge counter
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         edges_q <= apms_pkg::EDGE_ZERO;
      end else if (link.sel_fall) begin
         edges_q <= apms_pkg::EDGE_ZERO; // RQ17
      end else if (link.clk_fall && edges_q != apms_pkg::EDGE_FRAME) begin
         edges_q <= edges_q + 5'h01; // RQ17
      end
   end

   // ----------------------------------------
   // Rising-edge counter
   // ----------------------------------------
   // Kept apart from the fall count so track timing does not hang on the clock's idle level
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rises_q <= apms_pkg::EDGE_ZERO;
      end else if (link.sel_fall) begin
         rises_q <= apms_pkg::EDGE_ZERO; // RQ14
      end else if (link.clk_rise && rises_q != apms_pkg::EDGE_FRAME) begin
         rises_q <= rises_q + 5'h01; // RQ14
      end
   end

   // ----------------------------------------
   // Frame activity
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         active_q <= 1'b0;
      end else if (link.sel_fall) begin
         active_q <= 1'b1; // RQ1
      end else if (link.sel_rise) begin
         active_q <= 1'b0;
      end else if (link.clk_fall && edges_q == apms_pkg::EDGE_FRAME - 5'h01) begin
         active_q <= 1'b0; // RQ4
      end
   end

   // ----------------------------------------
   // Mode machine
   // ----------------------------------------
   // Only a frame still open is judged; a completed frame has already settled its mode
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_q <= apms_pkg::MODE_RESET;
      end else if (link.sel_rise && active_q) begin
         case (mode_q)
            apms_pkg::APMS_NORMAL: begin
               if (in_window(edges_q, apms_pkg::EDGE_GLITCH, apms_pkg::EDGE_HOLD)) begin
                  mode_q <= apms_pkg::APMS_PARTIAL; // RQ7 RQ13
               end else begin
                  mode_q <= apms_pkg::APMS_NORMAL; // RQ8 RQ3 RQ2
               end
            end
            apms_pkg::APMS_PARTIAL: begin
               if (in_window(edges_q, apms_pkg::EDGE_GLITCH, apms_pkg::EDGE_HOLD)) begin
                  mode_q <= apms_pkg::APMS_FULL; // RQ12 RQ13
               end else if (edges_q >= apms_pkg::EDGE_HOLD) begin
                  mode_q <= apms_pkg::APMS_NORMAL; // RQ9
               end else begin
                  mode_q <= apms_pkg::APMS_PARTIAL; // RQ11
               end
            end
            apms_pkg::APMS_FULL: begin
               if (edges_q >= apms_pkg::EDGE_HOLD) begin
                  mode_q <= apms_pkg::APMS_NORMAL; // RQ9
               end else begin
                  mode_q <= apms_pkg::APMS_FULL;
               end
            end
            default: begin
               mode_q <= apms_pkg::MODE_RESET;
            end
         endcase
      end else if (link.clk_fall && active_q && edges_q == apms_pkg::EDGE_FRAME - 5'h01
                   && mode_q != apms_pkg::APMS_NORMAL) begin
         mode_q <= apms_pkg::APMS_NORMAL; // RQ9 RQ10
      end
   end

   // ----------------------------------------
   // Wake tracking: any open frame, and whether it began in power-down
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         waking_q <= 1'b0;
         dummy_q <= 1'b0;
      end else if (link.sel_fall) begin
         waking_q <= 1'b1; // RQ9
         dummy_q <= (mode_q != apms_pkg::APMS_NORMAL); // RQ10
      end else if (link.sel_rise) begin
         waking_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Sample hold and shift register
   // ----------------------------------------
   // Word is loaded at the select fall; bit 15 is on the pin first
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         shift_q <= 16'h0000;
      end else if (link.sel_fall) begin
         shift_q <= {apms_pkg::LEAD_ZEROS, sample_code}; // RQ1 RQ15
      end else if (link.clk_fall && active_q) begin
         shift_q <= {shift_q[14:0], 1'b0}; // RQ15
      end
   end

   // ----------------------------------------
   // Output enable
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         oe_q <= 1'b0;
      end else if (link.sel_fall) begin
         oe_q <= 1'b1;
      end else if (!link.sel_low || link.sel_rise) begin
         oe_q <= 1'b0; // RQ18 RQ3 RQ7
      end else if (link.clk_fall && edges_q == apms_pkg::EDGE_FRAME - 5'h01) begin
         oe_q <= 1'b0; // RQ4
      end
   end

   // ----------------------------------------
   // Track-and-hold and valid flag
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         track_q <= 1'b1;
      end else if (link.sel_fall) begin
         track_q <= 1'b0; // RQ1
      end else if (link.clk_rise && rises_q == apms_pkg::EDGE_TRACK - 5'h01) begin
         track_q <= 1'b1; // RQ14
      end else if (link.clk_rise && dummy_q) begin
         track_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         valid_q <= 1'b0;
      end else if (link.sel_fall) begin
         valid_q <= 1'b0;
      end else if (link.clk_fall && active_q && !dummy_q && edges_q == apms_pkg::EDGE_FRAME - 5'h01) begin
         valid_q <= 1'b1; // RQ4 RQ10
      end
   end

   assign serial_result_out = shift_q[15];
   assign serial_result_oe = oe_q & link.sel_low; // RQ18
   assign power_mode = mode_q;
   assign powered = (mode_q == apms_pkg::APMS_NORMAL) | waking_q; // RQ2 RQ9
   assign tracking = track_q;
   assign result_valid = valid_q;

endmodule

// ---- dv/apms_seq_asserts.sv ----
// Checker for the power-mode sequencer.
// Bound to apms_seq; sees only its ports.
`timescale 1ns/1ns
module apms_seq_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sel_n_pin,
   input wire logic serial_result_oe,
   input wire logic [1:0] power_mode,
   input wire logic powered,
   input wire logic tracking,
   input wire logic result_valid
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   AST_OE_IDLE: assert property (sel_n_pin [*4] |-> !serial_result_oe)
      else $error("output enabled with select high");
   AST_MODE_CODE: assert property (power_mode != 2'h2)
      else $error("illegal mode code");
   AST_NO_SKIP: assert property (power_mode == apms_pkg::APMS_NORMAL |=> power_mode != apms_pkg::APMS_FULL)
      else $error("normal went straight to full");
   AST_FULL_HOLD: assert property (power_mode == apms_pkg::APMS_FULL |=> power_mode != apms_pkg::APMS_PARTIAL)
      else $error("full went back to partial");
   AST_POWERED: assert property (power_mode == apms_pkg::APMS_NORMAL |-> powered)
      else $error("normal mode not powered");
   AST_VALID_MODE: assert property ($rose(result_valid) |-> power_mode == apms_pkg::APMS_NORMAL)
      else $error("result valid outside normal mode");
   AST_OE_START: assert property ($rose(serial_result_oe) |-> $past(sel_n_pin, 2) == 1'b0)
      else $error("output enabled without select fall");
   AST_TRACK: assert property ($rose(tracking) |-> $past(sel_n_pin, 3) == 1'b0)
      else $error("tracking outside a frame");
   cover property (power_mode == apms_pkg::APMS_PARTIAL);
   cover property (power_mode == apms_pkg::APMS_FULL);
   cover property ($rose(result_valid));
endmodule

// ---- dv/apms_host_model.sv ----
// Host serial master: drives select and serial clock.
// Serial clock idles high and stands still outside frames.
`timescale 1ns/1ns
module apms_host_model (
   input wire logic clk,
   input wire logic serial_result_out,
   input wire logic serial_result_oe,
   output logic sel_n_pin,
   output logic sclk_pin
);
   initial begin
      sel_n_pin = 1'b1;
      sclk_pin = 1'b1;
   end
   // Word holds the bit seen before each fall, z where not driven
   task automatic frame(input int nfall, output logic [15:0] word);
      word = 16'hXXXX;
      @(posedge clk) #1;
      sel_n_pin = 1'b0;
      #400;
      for (int k = 0; k < nfall; k++) begin
         if (k < 16) begin
            word = {word[14:0], serial_result_oe ? serial_result_out : 1'bz};
         end
         sclk_pin = 1'b0;
         #400;
         sclk_pin = 1'b1;
         #400;
      end
      sel_n_pin = 1'b1;
      #1000;
   endtask
endmodule

// ---- dv/apms_seq_tb_top.sv ----
// Self-checking bench for the power-mode sequencer.
// Needs apms_pkg, apms_seq, host model and checker.
`timescale 1ns/1ns
module apms_seq_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] sample_code = 12'h000;
   logic sel_n_pin, sclk_pin, serial_result_out, serial_result_oe, powered, tracking, result_valid;
   logic [1:0] power_mode;
   logic [15:0] word;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   always #50 clk = ~clk;
   apms_seq dut_u (.clk(clk), .rst_n(rst_n), .sel_n_pin(sel_n_pin), .sclk_pin(sclk_pin), .sample_code(sample_code),
      .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe), .power_mode(power_mode),
      .powered(powered), .tracking(tracking), .result_valid(result_valid));
   apms_host_model host_u (.clk(clk), .serial_result_out(serial_result_out),
      .serial_result_oe(serial_result_oe), .sel_n_pin(sel_n_pin), .sclk_pin(sclk_pin));
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic t_read(input logic [11:0] code);
      @(posedge clk) #1;
      sample_code = code;
      host_u.frame(16, word);
      chk("word", {4'h0, code}, word);
      chk("result_valid", 16'h0001, {15'h0000, result_valid});
      chk("tracking", 16'h0001, {15'h0000, tracking});
   endtask
   // Walk through the mode table, ending on a dummy frame from full
   task automatic t_modes;
      int nf[11] = '{1, 2, 1, 9, 10, 9, 10, 12, 5, 5, 16};
      logic [1:0] md[11] = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h3, 2'h0};
      for (int i = 0; i < 11; i++) begin
         host_u.frame(nf[i], word);
         chk("power_mode", {14'h0000, md[i]}, {14'h0000, power_mode});
         if (nf[i] == 12) begin
            chk("abort_tracking", 16'h0000, {15'h0000, tracking});
            chk("abort_valid", 16'h0000, {15'h0000, result_valid});
         end
      end
      chk("dummy_valid", 16'h0000, {15'h0000, result_valid});
      chk("powered", 16'h0001, {15'h0000, powered});
   endtask
   task automatic stop_test;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk);
      t_read(12'hA5C);
      t_modes;
      #2000;
      t_read(12'hFFF);
      t_read(12'h001);
      stop_test;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         miscompares++;
         stop_test;
      end
   end
endmodule
bind apms_seq apms_seq_asserts chk_u (.clk(clk), .rst_n(rst_n), .sel_n_pin(sel_n_pin),
   .serial_result_oe(serial_result_oe), .power_mode(power_mode), .powered(powered), .tracking(tracking),
   .result_valid(result_valid));
